// file: core/dhp_pkg.sv
// Shared types and constants for the dual-channel serial host port.
// Assumes a single 40 MHz system clock and synchronous, active-high reset.
package dhp_pkg;

  // Output pin 2 function select codes
  localparam logic [1:0] OP2_SEL_GPO    = 2'h0;
  localparam logic [1:0] OP2_SEL_TXA16  = 2'h1;
  localparam logic [1:0] OP2_SEL_TXA1   = 2'h2;
  localparam logic [1:0] OP2_SEL_RXA1   = 2'h3;

  // Output pin 3 function select codes
  localparam logic [1:0] OP3_SEL_GPO    = 2'h0;
  localparam logic [1:0] OP3_SEL_CT     = 2'h1;
  localparam logic [1:0] OP3_SEL_TXB1   = 2'h2;
  localparam logic [1:0] OP3_SEL_RXB1   = 2'h3;

  // Values after reset
  localparam logic [7:0] DATA_RST       = 8'h00;
  localparam logic [3:0] ADDR_RST       = 4'h0;
  localparam logic       PIN_HIGH_RST   = 1'b1;
  localparam logic       OE_N_RST       = 1'b1;
  localparam logic [5:0] IN_PINS_RST    = 6'h3F;

  // Input pin positions
  localparam int IP_CTS_A   = 0;
  localparam int IP_CTS_B   = 1;
  localparam int IP_CT_CLK  = 2;
  localparam int IP_TXCLK_A = 3;
  localparam int IP_RXCLK_A = 4;
  localparam int IP_TXCLK_B = 5;

  // Register access requested of the register core
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [3:0] addr;
    logic [7:0] wdata;
  } dhp_req_s;

  // Pin function selection held by the register core
  typedef struct packed {
    logic       ip0_cts;
    logic       ip1_cts;
    logic       ip2_ct_clk;
    logic       ip3_tx_clk;
    logic       ip4_rx_clk;
    logic       ip5_tx_clk;
    logic       op0_rts;
    logic       op1_rts;
    logic [1:0] op2_sel;
    logic [1:0] op3_sel;
  } dhp_pin_cfg_s;

  // Signals from the channels and counter/timer for the output pins
  typedef struct packed {
    logic [3:0] gpo;
    logic       rts_a_n;
    logic       rts_b_n;
    logic       txclk_a_16x;
    logic       txclk_a_1x;
    logic       rxclk_a_1x;
    logic       txclk_b_1x;
    logic       rxclk_b_1x;
    logic       ct_out_n;
  } dhp_core_pins_s;

  // Input pin functions handed to the channels and counter/timer
  typedef struct packed {
    logic [5:0] gpi;
    logic       cts_a_n;
    logic       cts_b_n;
    logic       ct_ext_tick;
    logic       tx_a_shift;
    logic       rx_a_sample;
    logic       tx_b_shift;
  } dhp_pin_evt_s;

endpackage

// file: core/dhp_host_port.sv
// Parallel host port of a dual-channel serial controller, 68xxx-style bus,
// with input and output pin function steering.
// Assumes all pins are already synchronous to sys_clk and that the register
// core answers reg_rdata in the same cycle that req.rd is high.
//
// Overview of operation
// - Register transfers happen only while chip select is low, never while high.
// - Data bus lines are released whenever chip select and interrupt acknowledge are both high.
// - Four address inputs pick the target register on every access.
// - Eight-bit bidirectional data bus, line 0 is the least significant bit.
// - Transfer acknowledge goes low in every read, write and vector cycle.
// - Interrupt acknowledge low puts the vector on the bus and acknowledges.
// - Open-drain interrupt request is low while any of eight conditions holds.
// - Strap high or open selects this 68xxx-style signal set.
// - Input pins 0 and 1 are general inputs or clear-to-send A and B.
// - Input pin 2 is a general input or counter/timer external clock.
// - External transmit clocks on pins 3 and 5 shift on falling edges.
// - External receive clock on pin 4 samples on its rising edge.
// - Output pins 0 and 1 are general outputs or request-to-send A and B.
// - Output pin 2 is general, A transmit 1x or 16x, or A receive clock.
// - Output pin 3 is general, timer open-drain, or B bit-rate clocks.
// - Direction high with chip select low reads, low writes.
// - Reset clears core registers, raises outputs and idles the channels.
`timescale 1ns/1ps
`default_nettype none

module dhp_host_port (
  input  wire logic                    sys_clk,
  input  wire logic                    srst,
  input  wire logic                    reset_n_a,
  input  wire logic                    bus_mode_strap,
  input  wire logic                    chip_select_n,
  input  wire logic                    read_not_write,
  input  wire logic [3:0]              addr_in,
  input  wire logic                    int_ack_n,
  input  wire logic [7:0]              data_in,
  output logic      [7:0]              data_out,
  output logic                         data_oe_n,
  output logic                         transfer_ack_n,
  output logic                         irq_out,
  output logic                         irq_oe_n,
  input  wire logic [5:0]              in_pins,
  output logic                         out_pin_0,
  output logic                         out_pin_1,
  output logic                         out_pin_2,
  output logic                         out_pin_3,
  output logic                         out_pin_3_oe_n,
  output logic                         core_reset,
  output dhp_pkg::dhp_req_s            req,
  input  wire logic [7:0]              reg_rdata,
  input  wire logic [7:0]              int_vector,
  input  wire logic [7:0]              int_active,
  input  wire dhp_pkg::dhp_pin_cfg_s   pin_cfg,
  input  wire dhp_pkg::dhp_core_pins_s core_pins,
  output dhp_pkg::dhp_pin_evt_s        pin_evt
);

  typedef enum logic [1:0] {
    DHP_IDLE,
    DHP_READ,
    DHP_HOLD
  } dhp_state_e;

  dhp_state_e               state_reg;
  dhp_state_e               state_next;
  logic                     iack_cyc_reg;
  logic                     iack_cyc_next;
  logic [7:0]               data_out_reg;
  logic [7:0]               data_out_next;
  logic                     data_oe_n_reg;
  logic                     data_oe_n_next;
  logic                     ack_n_reg;
  logic                     ack_n_next;
  dhp_pkg::dhp_req_s        req_reg;
  dhp_pkg::dhp_req_s        req_next;
  logic                     any_rst;
  logic                     port_on;

  // Pin reset clears like the system reset; it also resets the core
  assign any_rst = srst || !reset_n_a;
  assign port_on = bus_mode_strap;

  // Bus cycle sequencing; interrupt acknowledge wins over a register access
  always_comb begin
    state_next     = state_reg;
    iack_cyc_next  = iack_cyc_reg;
    data_out_next  = data_out_reg;
    data_oe_n_next = data_oe_n_reg;
    ack_n_next     = ack_n_reg;
    req_next       = req_reg;
    req_next.rd    = 1'b0;
    req_next.wr    = 1'b0;
    case (state_reg)
      DHP_IDLE: begin
        if (port_on && !int_ack_n) begin
          data_out_next  = int_vector;
          data_oe_n_next = 1'b0;
          ack_n_next     = 1'b0;
          iack_cyc_next  = 1'b1;
          state_next     = DHP_HOLD;
        end else if (port_on && !chip_select_n) begin
          req_next.addr = addr_in;
          iack_cyc_next = 1'b0;
          if (read_not_write) begin
            req_next.rd = 1'b1;
            state_next  = DHP_READ;
          end else begin
            req_next.wr    = 1'b1;
            req_next.wdata = data_in;
            ack_n_next     = 1'b0;
            state_next     = DHP_HOLD;
          end
        end
      end
      DHP_READ: begin
        // Core answers during the strobe cycle, so capture and present now
        data_out_next  = reg_rdata;
        data_oe_n_next = chip_select_n;
        ack_n_next     = chip_select_n;
        state_next     = chip_select_n ? DHP_IDLE : DHP_HOLD;
      end
      DHP_HOLD: begin
        // The CPU ends the cycle; no new access until the strobe rises
        if (iack_cyc_reg ? int_ack_n : chip_select_n) begin
          data_oe_n_next = 1'b1;
          ack_n_next     = 1'b1;
          state_next     = DHP_IDLE;
        end
      end
      default: begin
        state_next     = DHP_IDLE;
        data_oe_n_next = 1'b1;
        ack_n_next     = 1'b1;
      end
    endcase
  end

  // Bus cycle registers
  always_ff @(posedge sys_clk) begin
    if (any_rst) begin
      state_reg     <= DHP_IDLE;
      iack_cyc_reg  <= 1'b0;
      data_out_reg  <= dhp_pkg::DATA_RST;
      data_oe_n_reg <= dhp_pkg::OE_N_RST;
      ack_n_reg     <= dhp_pkg::PIN_HIGH_RST;
      req_reg       <= '0;
    end else begin
      state_reg     <= state_next;
      iack_cyc_reg  <= iack_cyc_next;
      data_out_reg  <= data_out_next;
      data_oe_n_reg <= data_oe_n_next;
      ack_n_reg     <= ack_n_next;
      req_reg       <= req_next;
    end
  end

  assign data_out       = data_out_reg;
  assign data_oe_n      = data_oe_n_reg;
  assign transfer_ack_n = ack_n_reg;
  assign req            = req_reg;

  // Pin steering state
  logic                 irq_oe_n_reg;
  logic                 irq_oe_n_next;
  logic [3:0]           op_reg;
  logic [3:0]           op_next;
  logic                 op3_oe_n_reg;
  logic                 op3_oe_n_next;
  logic [5:0]           ip_prev_reg;
  dhp_pkg::dhp_pin_evt_s evt_reg;
  dhp_pkg::dhp_pin_evt_s evt_next;
  logic                 core_rst_reg;
  logic [5:0]           fall;
  logic [5:0]           rise;
  logic [5:0]           ext_en;

  // Edge detection per input pin; inputs are already synchronous
  assign ext_en = {pin_cfg.ip5_tx_clk, pin_cfg.ip4_rx_clk,
                   pin_cfg.ip3_tx_clk, pin_cfg.ip2_ct_clk,
                   pin_cfg.ip1_cts, pin_cfg.ip0_cts};
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi = gi + 1) begin : g_edge
      assign fall[gi] = ext_en[gi] && ip_prev_reg[gi] && !in_pins[gi];
      assign rise[gi] = ext_en[gi] && !ip_prev_reg[gi] && in_pins[gi];
    end
  endgenerate

  // Next values of interrupt, output pins and input functions
  always_comb begin
    irq_oe_n_next = !(|int_active);
    op_next[0] = pin_cfg.op0_rts ? core_pins.rts_a_n : core_pins.gpo[0];
    op_next[1] = pin_cfg.op1_rts ? core_pins.rts_b_n : core_pins.gpo[1];
    case (pin_cfg.op2_sel)
      dhp_pkg::OP2_SEL_TXA16: op_next[2] = core_pins.txclk_a_16x;
      dhp_pkg::OP2_SEL_TXA1:  op_next[2] = core_pins.txclk_a_1x;
      dhp_pkg::OP2_SEL_RXA1:  op_next[2] = core_pins.rxclk_a_1x;
      default:                op_next[2] = core_pins.gpo[2];
    endcase
    op3_oe_n_next = 1'b0;
    case (pin_cfg.op3_sel)
      dhp_pkg::OP3_SEL_CT: begin
        // Open drain: only ever pulls low, the board pull-up gives high
        op_next[3]    = 1'b0;
        op3_oe_n_next = core_pins.ct_out_n;
      end
      dhp_pkg::OP3_SEL_TXB1: op_next[3] = core_pins.txclk_b_1x;
      dhp_pkg::OP3_SEL_RXB1: op_next[3] = core_pins.rxclk_b_1x;
      default:               op_next[3] = core_pins.gpo[3];
    endcase
    evt_next.gpi         = in_pins;
    evt_next.cts_a_n     = pin_cfg.ip0_cts ? in_pins[dhp_pkg::IP_CTS_A]
                                           : 1'b0;
    evt_next.cts_b_n     = pin_cfg.ip1_cts ? in_pins[dhp_pkg::IP_CTS_B]
                                           : 1'b0;
    evt_next.ct_ext_tick = rise[dhp_pkg::IP_CT_CLK];
    evt_next.tx_a_shift  = fall[dhp_pkg::IP_TXCLK_A];
    evt_next.rx_a_sample = rise[dhp_pkg::IP_RXCLK_A];
    evt_next.tx_b_shift  = fall[dhp_pkg::IP_TXCLK_B];
  end

  // Pin registers; reset drives every output pin high and idles events
  always_ff @(posedge sys_clk) begin
    if (any_rst) begin
      irq_oe_n_reg <= dhp_pkg::OE_N_RST;
      op_reg       <= {4{dhp_pkg::PIN_HIGH_RST}};
      op3_oe_n_reg <= 1'b0;
      ip_prev_reg  <= dhp_pkg::IN_PINS_RST;
      evt_reg      <= '0;
      core_rst_reg <= 1'b1;
    end else begin
      irq_oe_n_reg <= irq_oe_n_next;
      op_reg       <= op_next;
      op3_oe_n_reg <= op3_oe_n_next;
      ip_prev_reg  <= in_pins;
      evt_reg      <= evt_next;
      core_rst_reg <= 1'b0;
    end
  end

  assign irq_out        = 1'b0;
  assign irq_oe_n       = irq_oe_n_reg;
  assign out_pin_0      = op_reg[0];
  assign out_pin_1      = op_reg[1];
  assign out_pin_2      = op_reg[2];
  assign out_pin_3      = op_reg[3];
  assign out_pin_3_oe_n = op3_oe_n_reg;
  assign pin_evt        = evt_reg;
  assign core_reset     = core_rst_reg;

endmodule

`default_nettype wire

// file: dv/dhp_host_port_asserts.sv
// Checker for the host port: bus cycles, interrupt line, pin steering.
// Bound onto dhp_host_port; sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module dhp_host_port_asserts (
  input wire logic                    sys_clk,
  input wire logic                    srst,
  input wire logic                    reset_n_a,
  input wire logic                    bus_mode_strap,
  input wire logic                    chip_select_n,
  input wire logic                    int_ack_n,
  input wire logic [7:0]              data_out,
  input wire logic                    data_oe_n,
  input wire logic                    transfer_ack_n,
  input wire logic                    irq_oe_n,
  input wire logic [5:0]              in_pins,
  input wire logic                    out_pin_2,
  input wire dhp_pkg::dhp_req_s       req,
  input wire logic [7:0]              reg_rdata,
  input wire logic [7:0]              int_vector,
  input wire logic [7:0]              int_active,
  input wire dhp_pkg::dhp_pin_cfg_s   pin_cfg,
  input wire dhp_pkg::dhp_core_pins_s core_pins,
  input wire dhp_pkg::dhp_pin_evt_s   pin_evt
);
  // One domain, so clock and reset are given once
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst || !reset_n_a);

  bus_release_a: assert property (
    (chip_select_n && int_ack_n)[*2] |-> data_oe_n)
    else $error("data bus driven with no cycle open");
  strap_off_a: assert property (
    !bus_mode_strap[*2] |-> transfer_ack_n && data_oe_n)
    else $error("cycle answered with strap low");
  read_answer_a: assert property (
    req.rd |=> !transfer_ack_n && !data_oe_n && data_out == $past(reg_rdata))
    else $error("read data or ack wrong");
  vector_cycle_a: assert property (
    !int_ack_n && chip_select_n && transfer_ack_n && data_oe_n &&
    bus_mode_strap |=> !transfer_ack_n && data_out == $past(int_vector))
    else $error("vector cycle wrong");
  irq_level_a: assert property (
    1'b1 |=> irq_oe_n == ~|$past(int_active))
    else $error("interrupt line wrong");
  ack_release_a: assert property (
    !transfer_ack_n && chip_select_n && int_ack_n |=> transfer_ack_n)
    else $error("ack held after cycle end");
  op2_general_a: assert property (
    pin_cfg.op2_sel == dhp_pkg::OP2_SEL_GPO |=>
    out_pin_2 == $past(core_pins.gpo[2]))
    else $error("output pin 2 wrong");
  tx_shift_a: assert property (
    pin_cfg.ip3_tx_clk && $fell(in_pins[3]) |=> pin_evt.tx_a_shift)
    else $error("no shift on falling transmit clock");
endmodule

bind dhp_host_port dhp_host_port_asserts u_chk (
  .sys_clk, .srst, .reset_n_a, .bus_mode_strap, .chip_select_n, .int_ack_n,
  .data_out, .data_oe_n, .transfer_ack_n, .irq_oe_n, .in_pins, .out_pin_2,
  .req, .reg_rdata, .int_vector, .int_active, .pin_cfg, .core_pins, .pin_evt);
`default_nettype wire

// file: dv/dhp_cpu_model.sv
// CPU bus model: one read, write or vector cycle at a time.
// Expects the port's ack and a resolved data bus beside it.
`timescale 1ns/1ps
`default_nettype none
module dhp_cpu_model (
  input  wire logic       sys_clk,
  input  wire logic       transfer_ack_n,
  input  wire logic [7:0] bus,
  output var  logic       chip_select_n,
  output var  logic       read_not_write,
  output var  logic [3:0] addr_in,
  output var  logic       int_ack_n,
  output var  logic       drive,
  output var  logic [7:0] wdat
);
  // Idle bus: nothing selected
  initial begin
    chip_select_n = 1'b1;
    int_ack_n = 1'b1;
    read_not_write = 1'b1;
    addr_in = 4'h0;
    drive = 1'b0;
    wdat = 8'h00;
  end

  // Holds the request until ack is sampled; gives up after 20 edges
  task automatic cycle(input logic rnw, vec, input logic [3:0] a,
                       input logic [7:0] d, output logic ok,
                       output logic [7:0] rd);
    @(posedge sys_clk);
    #2;
    read_not_write = rnw;
    addr_in = a;
    wdat = d;
    drive = !rnw && !vec;
    if (vec)
      int_ack_n = 1'b0;
    else
      chip_select_n = 1'b0;
    repeat (20) begin
      @(posedge sys_clk);
      #2;
      if (transfer_ack_n === 1'b0)
        break;
    end
    ok = (transfer_ack_n === 1'b0);
    rd = bus;
    @(posedge sys_clk);
    #2;
    chip_select_n = 1'b1;
    int_ack_n = 1'b1;
    drive = 1'b0;
    repeat (3) @(posedge sys_clk);
    #2;
  endtask
endmodule
`default_nettype wire

// file: dv/testbench.sv
// Testbench for the host port: bus cycles, interrupt and pin steering.
// CPU model on the bus; register core answers {~addr, addr}.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic                    sys_clk, srst, reset_n_a, bus_mode_strap, ok;
  logic                    chip_select_n, read_not_write, int_ack_n, drive;
  logic                    data_oe_n, transfer_ack_n, irq_out, irq_oe_n;
  logic                    out_pin_0, out_pin_1, out_pin_2, out_pin_3;
  logic                    out_pin_3_oe_n, core_reset;
  logic [3:0]              addr_in;
  logic [5:0]              in_pins;
  logic [7:0]              bus, data_out, wdat, rd, reg_rdata;
  logic [7:0]              int_vector, int_active;
  logic [11:0]             wr_log;
  int                      errors, comparisons, cycles;
  dhp_pkg::dhp_req_s       req;
  dhp_pkg::dhp_pin_cfg_s   pin_cfg;
  dhp_pkg::dhp_core_pins_s core_pins;
  dhp_pkg::dhp_pin_evt_s   pin_evt;

  dhp_host_port dut (
    .sys_clk, .srst, .reset_n_a, .bus_mode_strap, .chip_select_n,
    .read_not_write, .addr_in, .int_ack_n, .data_in(bus), .data_out,
    .data_oe_n, .transfer_ack_n, .irq_out, .irq_oe_n, .in_pins, .out_pin_0,
    .out_pin_1, .out_pin_2, .out_pin_3, .out_pin_3_oe_n, .core_reset, .req,
    .reg_rdata, .int_vector, .int_active, .pin_cfg, .core_pins, .pin_evt);
  dhp_cpu_model cpu (.sys_clk, .transfer_ack_n, .bus, .chip_select_n,
    .read_not_write, .addr_in, .int_ack_n, .drive, .wdat);

  // Released bus shows the inverse of the last byte, not a stale copy
  assign bus = !data_oe_n ? data_out : (drive ? wdat : ~wdat);
  assign reg_rdata = {~req.addr, req.addr};

  // 40 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // Last write handed to the core
  always @(posedge sys_clk)
    if (req.wr === 1'b1)
      wr_log <= {req.addr, req.wdata};

  // Ceiling on run length so a lost ack still ends the run
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 2000) begin
      errors++;
      stop_test();
    end
  end

  task automatic check(input logic [11:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask

  task automatic stop_test;
    if (errors == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic wait2;
    repeat (2) @(posedge sys_clk);
    #2;
  endtask

  task automatic t_write;
    cpu.cycle(1'b0, 1'b0, 4'hA, 8'h3C, ok, rd);
    check({11'h000, ok}, 12'h001);
    check(wr_log, 12'hA3C);
  endtask

  // Every address, back to back; data bit order checked through the pattern
  task automatic t_read;
    for (int a = 0; a < 16; a++) begin
      cpu.cycle(1'b1, 1'b0, 4'(a), 8'h00, ok, rd);
      check({3'h0, ok, rd}, {4'h1, ~4'(a), 4'(a)});
    end
  endtask

  task automatic t_vector;
    cpu.cycle(1'b1, 1'b1, 4'h0, 8'h00, ok, rd);
    check({ok, 3'h0, rd}, 12'h85A);
  endtask

  // Strap low: the cycle must go unanswered and nothing is written
  task automatic t_strap;
    bus_mode_strap = 1'b0;
    cpu.cycle(1'b0, 1'b0, 4'h3, 8'hC3, ok, rd);
    check({ok, wr_log[10:0]}, 12'h23C);
    bus_mode_strap = 1'b1;
  endtask

  task automatic t_irq;
    int_active = 8'h10;
    wait2();
    check({10'h000, irq_out, irq_oe_n}, 12'h000);
    int_active = 8'h00;
    wait2();
    check({10'h000, irq_out, irq_oe_n}, 12'h001);
  endtask

  // Each output pin 2 source in turn, only the selected one high
  task automatic t_pins;
    for (int s = 0; s < 4; s++) begin
      pin_cfg.op2_sel = 2'(s);
      core_pins = '0;
      core_pins.gpo[2] = (s == 0);
      core_pins.txclk_a_16x = (s == 1);
      core_pins.txclk_a_1x = (s == 2);
      core_pins.rxclk_a_1x = (s == 3);
      wait2();
      check({11'h000, out_pin_2}, 12'h001);
    end
    // General levels high so a wrong pick of source shows up
    core_pins.gpo = 4'hF;
    core_pins.ct_out_n = 1'b1;
    pin_cfg.op3_sel = dhp_pkg::OP3_SEL_CT;
    pin_cfg.op0_rts = 1'b1;
    pin_cfg.op1_rts = 1'b1;
    pin_cfg.ip0_cts = 1'b1;
    pin_cfg.ip1_cts = 1'b1;
    pin_cfg.ip3_tx_clk = 1'b1;
    in_pins = 6'h37;
    wait2();
    // Timer output inactive: driven value low, enable off
    check({10'h000, out_pin_3, out_pin_3_oe_n}, 12'h001);
    check({10'h000, out_pin_0, out_pin_1}, 12'h000);
    check({10'h000, pin_evt.cts_a_n, pin_evt.cts_b_n}, 12'h003);
    pin_cfg.op3_sel = dhp_pkg::OP3_SEL_TXB1;
    core_pins.gpo[3] = 1'b0;
    core_pins.txclk_b_1x = 1'b1;
    wait2();
    check({10'h000, out_pin_3, out_pin_3_oe_n}, 12'h002);
    pin_cfg.op3_sel = dhp_pkg::OP3_SEL_RXB1;
    core_pins.txclk_b_1x = 1'b0;
    core_pins.rxclk_b_1x = 1'b1;
    wait2();
    check({10'h000, out_pin_3, out_pin_3_oe_n}, 12'h002);
    in_pins = 6'h3F;
    wait2();
  endtask

  // Edge pulses last one cycle, so each is looked at right after its edge
  task automatic t_edges;
    pin_cfg.ip2_ct_clk = 1'b1;
    pin_cfg.ip4_rx_clk = 1'b1;
    pin_cfg.ip5_tx_clk = 1'b1;
    in_pins = 6'h0B;
    @(posedge sys_clk);
    #2;
    check({8'h00, pin_evt.ct_ext_tick, pin_evt.rx_a_sample,
           pin_evt.tx_b_shift, pin_evt.tx_a_shift}, 12'h002);
    check({6'h00, pin_evt.gpi}, 12'h00B);
    in_pins = 6'h3F;
    @(posedge sys_clk);
    #2;
    check({11'h000, pin_evt.ct_ext_tick}, 12'h001);
    check({11'h000, pin_evt.rx_a_sample}, 12'h001);
    check({11'h000, pin_evt.tx_b_shift}, 12'h000);
  endtask

  task automatic t_reset;
    reset_n_a = 1'b0;
    wait2();
    check({4'h0, out_pin_0, out_pin_1, out_pin_2, out_pin_3,
           transfer_ack_n, data_oe_n, irq_oe_n, core_reset}, 12'h0FF);
    reset_n_a = 1'b1;
    wait2();
    check({11'h000, core_reset}, 12'h000);
    // Port must answer again straight after a mid-run reset
    cpu.cycle(1'b1, 1'b0, 4'h5, 8'h00, ok, rd);
    check({3'h0, ok, rd}, 12'h1A5);
  endtask

  // Reset, then each scenario in turn
  initial begin
    srst = 1'b1;
    reset_n_a = 1'b1;
    bus_mode_strap = 1'b1;
    in_pins = 6'h3F;
    int_active = 8'h00;
    int_vector = 8'h5A;
    pin_cfg = '0;
    core_pins = '0;
    wr_log = 12'h000;
    errors = 0;
    comparisons = 0;
    cycles = 0;
    repeat (12) @(posedge sys_clk);
    #2;
    srst = 1'b0;
    t_write();
    t_read();
    t_vector();
    t_strap();
    t_irq();
    t_pins();
    t_edges();
    t_reset();
    stop_test();
  end
endmodule
`default_nettype wire
